// File: design/sector_prot_defines.svh
// constants for the sector protection bit block
`ifndef SECTOR_PROT_DEFINES_SVH
`define SECTOR_PROT_DEFINES_SVH
// ----------------------------------------------------------------
// address map of one protection unit
// ----------------------------------------------------------------
`define PROT_ADDR_W 25
`define PROT_UNIT_LSB 18
`define PROT_NUM_UNITS 128
// ----------------------------------------------------------------
// reset and delivery values
// ----------------------------------------------------------------
`define PROT_PPB_ERASED 1'b1
`define PROT_PPB_PROGRAMMED 1'b0
`define PROT_DYB_UNPROT 1'b1
// ----------------------------------------------------------------
// timing: clock rate and typical operation times
// ----------------------------------------------------------------
`define PROT_CLK_MHZ 25
`define PROT_PROG_TIME_US 200
`define PROT_ERASE_TIME_US 50000
`define PROT_PROG_CYCLES (`PROT_PROG_TIME_US * `PROT_CLK_MHZ)
`define PROT_ERASE_CYCLES (`PROT_ERASE_TIME_US * `PROT_CLK_MHZ)
`endif

// File: design/sector_prot_pkg.sv
// types shared by the sector protection bit block
`include "sector_prot_defines.svh"
package sector_prot_pkg;
  // ----------------------------------------------------------------
  // command decoded by the serial front end
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    op_ppb_prog,
    op_ppb_erase,
    op_persistent_bit_read_cmd,
    op_dyb_write
  } prot_op_type;

  typedef struct packed {
    logic valid;
    prot_op_type op;
    logic [`PROT_ADDR_W-1:0] addr;
    logic wdata;
  } prot_cmd_type;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle,
    st_prog,
    st_preprog,
    st_erase
  } prot_state_type;
endpackage

// File: design/prot_busy_timer.sv
// down counter that times a persistent bit operation
`timescale 1ns/1ps
module prot_busy_timer #(
  parameter int CNT_W = 32
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // start request
  input wire logic i_load,
  input wire logic [CNT_W-1:0] i_cycles,
  // end of the timed interval
  output logic o_done
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] count; // cycles left
    logic done;              // one-cycle end pulse
  } timer_type;
  timer_type state_reg;
  timer_type state_next;

  // a one-bit counter cannot tell the last count from idle
  if (CNT_W < 2) begin : g_bad_cnt_w
    $error("prot_busy_timer: CNT_W too small");
  end

  // next state: load wins over counting so back to back phases chain
  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    if (i_sys_rst) begin
      state_next = '0;
    end else if (i_load) begin
      state_next.count = i_cycles;
    end else if (state_reg.count != '0) begin
      state_next.count = state_reg.count - 1'b1;
      state_next.done = (state_reg.count == {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end

  // register
  always_ff @(posedge i_clk) begin
    state_reg <= state_next;
  end

  assign o_done = state_reg.done;

  // a pulse only ever follows the last count
  a_timer_done_end: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_done |-> $past(state_reg.count) == 1 && state_reg.count == 0)
    else $error("timer done without final count");
endmodule

// File: design/sector_protection_bits.sv
// persistent and volatile protection bits of the serial flash, one pair per 256KB block
`timescale 1ns/1ps
`include "sector_prot_defines.svh"

// Function
// - one non-volatile persistent bit per unit
// - 256KB mode: each bit governs one block
// - program one bit, erase all together
// - program drives 0, erase sets all 1
// - erase preprograms internally before erasing
// - program ~page time, erase ~sector time
// - busy reported while program or erase runs
// - no array reads during persistent program
// - no single-bit erase, erase needs no address
// - read command returns selected persistent bit
// - factory state of persistent bits is 1
// - one individually writable volatile bit per unit
// - volatile bit matters only if persistent is 1
// - volatile write stores 0 protect, 1 unprotect
// - volatile bits rewrite without endurance limit
// - lock at 0 rejects program and erase
// - reset returns volatile bits to unprotected
module sector_protection_bits #(
  parameter int NUM_UNITS = `PROT_NUM_UNITS,
  parameter int ADDR_W = `PROT_ADDR_W,
  parameter int UNIT_LSB = `PROT_UNIT_LSB,
  parameter int PROG_CYCLES = `PROT_PROG_CYCLES,
  parameter int ERASE_CYCLES = `PROT_ERASE_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // configuration and lock
  input wire logic i_blk_size_256k,
  input wire logic i_persistent_bits_lock,
  // decoded protection command
  input wire sector_prot_pkg::prot_cmd_type i_cmd,
  // array protection query
  input wire logic [ADDR_W-1:0] i_chk_addr,
  // status
  output logic o_busy,
  output logic o_cmd_fail,
  output logic o_array_read_block,
  // persistent bit read answer
  output logic o_rd_valid,
  output logic o_rd_data,
  // array write protection for the queried address
  output logic o_chk_protected
);
  localparam int UW = ADDR_W - UNIT_LSB;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the command struct carries a fixed address width
  if (ADDR_W != `PROT_ADDR_W) begin : g_bad_addr_w
    $error("ADDR_W must match the command address width");
  end
  // every unit index decoded from the address must have a bit pair
  if (NUM_UNITS != (1 << UW)) begin : g_bad_units
    $error("NUM_UNITS must cover the address space");
  end
  // a zero load never ends the timer, so busy would stick
  if (PROG_CYCLES < 1 || ERASE_CYCLES < 1) begin : g_bad_times
    $error("operation times must be positive");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_UNITS-1:0] persistent_protect_bit;    // persistent bits, 1 = erased
    logic [NUM_UNITS-1:0] volatile_protect_bit;    // volatile bits, 1 = unprotected
    sector_prot_pkg::prot_state_type st;
    logic [UW-1:0] tgt;           // unit being programmed
    logic erase_op;               // current operation is the group erase
    logic busy;
    logic fail;
    logic rd_valid;
    logic rd_data;
    logic chk_prot;
  } state_type;

  // persistent bits hold their delivery value until changed; no reset touches them
  state_type state_reg = '{persistent_protect_bit: {NUM_UNITS{`PROT_PPB_ERASED}},
                           volatile_protect_bit: {NUM_UNITS{`PROT_DYB_UNPROT}},
                           st: sector_prot_pkg::st_idle, default: '0};
  state_type state_next;
  logic tmr_load;
  logic [31:0] tmr_cycles;
  logic tmr_done;
  logic [UW-1:0] cmd_unit;
  logic [UW-1:0] chk_unit;

  // upper address bits select the unit; low bits are ignored
  function automatic logic [UW-1:0] unit_of(input logic [ADDR_W-1:0] addr);
    unit_of = addr[ADDR_W-1:UNIT_LSB];
  endfunction

  assign cmd_unit = unit_of(i_cmd.addr);
  assign chk_unit = unit_of(i_chk_addr);

  // ----------------------------------------------------------------
  // operation timer
  // ----------------------------------------------------------------
  prot_busy_timer #(
    .CNT_W(32)
  ) u_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(tmr_load),
    .i_cycles(tmr_cycles),
    .o_done(tmr_done)
  );

  // ----------------------------------------------------------------
  // command handling and sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.fail = 1'b0;
    state_next.rd_valid = 1'b0;
    tmr_load = 1'b0;
    tmr_cycles = '0;
    // either bit at 0 protects; volatile bit only matters under an erased persistent bit
    state_next.chk_prot = ~(state_reg.persistent_protect_bit[chk_unit] & state_reg.volatile_protect_bit[chk_unit]);
    if (i_cmd.valid) begin
      unique case (i_cmd.op)
        sector_prot_pkg::op_persistent_bit_read_cmd: begin
          // answer the selected persistent bit
          state_next.rd_valid = 1'b1;
          state_next.rd_data = state_reg.persistent_protect_bit[cmd_unit];
        end
        sector_prot_pkg::op_dyb_write: begin
          // volatile write is allowed any time, unlimited times
          state_next.volatile_protect_bit[cmd_unit] = i_cmd.wdata;
        end
        sector_prot_pkg::op_ppb_prog: begin
          // a locked set, a running operation or an unsupported size refuses
          if (!i_persistent_bits_lock || state_reg.busy || !i_blk_size_256k) begin
            state_next.fail = 1'b1;
          end else begin
            state_next.st = sector_prot_pkg::st_prog;
            state_next.tgt = cmd_unit;
            state_next.erase_op = 1'b0;
            state_next.busy = 1'b1;
            tmr_load = 1'b1;
            tmr_cycles = 32'(PROG_CYCLES);
          end
        end
        sector_prot_pkg::op_ppb_erase: begin
          // group erase: address is ignored
          if (!i_persistent_bits_lock || state_reg.busy || !i_blk_size_256k) begin
            state_next.fail = 1'b1;
          end else begin
            state_next.st = sector_prot_pkg::st_preprog;
            state_next.erase_op = 1'b1;
            state_next.busy = 1'b1;
            tmr_load = 1'b1;
            tmr_cycles = 32'(PROG_CYCLES);
          end
        end
      endcase
    end
    // completion of timed phases
    unique case (state_reg.st)
      sector_prot_pkg::st_idle: begin
      end
      sector_prot_pkg::st_prog: begin
        if (tmr_done) begin
          state_next.persistent_protect_bit[state_reg.tgt] = `PROT_PPB_PROGRAMMED;
          state_next.st = sector_prot_pkg::st_idle;
          state_next.busy = 1'b0;
        end
      end
      sector_prot_pkg::st_preprog: begin
        // preprogram and verify all cells before the erase pulse
        if (tmr_done) begin
          state_next.persistent_protect_bit = {NUM_UNITS{`PROT_PPB_PROGRAMMED}};
          state_next.st = sector_prot_pkg::st_erase;
          tmr_load = 1'b1;
          tmr_cycles = 32'(ERASE_CYCLES);
        end
      end
      sector_prot_pkg::st_erase: begin
        if (tmr_done) begin
          state_next.persistent_protect_bit = {NUM_UNITS{`PROT_PPB_ERASED}};
          state_next.st = sector_prot_pkg::st_idle;
          state_next.busy = 1'b0;
        end
      end
    endcase
    // reset keeps persistent bits, frees volatile ones, abandons any operation
    if (i_sys_rst) begin
      state_next.volatile_protect_bit = {NUM_UNITS{`PROT_DYB_UNPROT}};
      state_next.st = sector_prot_pkg::st_idle;
      state_next.tgt = '0;
      state_next.erase_op = 1'b0;
      state_next.busy = 1'b0;
      state_next.fail = 1'b0;
      state_next.rd_valid = 1'b0;
      state_next.rd_data = 1'b0;
      state_next.chk_prot = 1'b0;
      tmr_load = 1'b0;
    end
  end

  // register
  always_ff @(posedge i_clk) begin
    state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign o_busy = state_reg.busy;
  assign o_cmd_fail = state_reg.fail;
  assign o_array_read_block = state_reg.busy;
  assign o_rd_valid = state_reg.rd_valid;
  assign o_rd_data = state_reg.rd_data;
  assign o_chk_protected = state_reg.chk_prot;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  logic prog_req;
  logic erase_req;
  assign prog_req = i_cmd.valid && i_cmd.op == sector_prot_pkg::op_ppb_prog;
  assign erase_req = i_cmd.valid && i_cmd.op == sector_prot_pkg::op_ppb_erase;

  a_lock_rejects_change: assert property (
    (prog_req || erase_req) && !i_persistent_bits_lock |=> o_cmd_fail && !o_busy
      ##1 state_reg.persistent_protect_bit == $past(state_reg.persistent_protect_bit, 2))
    else $error("locked persistent bits changed or not refused");
  a_prog_goes_busy: assert property (
    prog_req && i_persistent_bits_lock && i_blk_size_256k && !o_busy
      |=> o_busy && !o_cmd_fail)
    else $error("accepted program did not raise busy");
  a_busy_blocks_read: assert property (
    state_reg.st == sector_prot_pkg::st_prog |-> o_array_read_block)
    else $error("array read not blocked during persistent program");
  a_prog_clears_bit: assert property (
    $fell(o_busy) && !state_reg.erase_op |-> state_reg.persistent_protect_bit[state_reg.tgt] == 1'b0)
    else $error("programmed persistent bit not 0");
  a_erase_sets_all: assert property (
    $fell(o_busy) && state_reg.erase_op |-> &state_reg.persistent_protect_bit)
    else $error("group erase left a bit at 0");
  a_erase_preprograms: assert property (
    state_reg.st == sector_prot_pkg::st_erase |-> state_reg.persistent_protect_bit == '0)
    else $error("erase phase without preprogram");
  a_dyb_write_value: assert property (
    i_cmd.valid && i_cmd.op == sector_prot_pkg::op_dyb_write
      |=> state_reg.volatile_protect_bit[$past(cmd_unit)] == $past(i_cmd.wdata))
    else $error("volatile bit write not stored");
  a_read_returns_bit: assert property (
    i_cmd.valid && i_cmd.op == sector_prot_pkg::op_persistent_bit_read_cmd && !tmr_done
      |=> o_rd_valid && o_rd_data == $past(state_reg.persistent_protect_bit[cmd_unit]))
    else $error("persistent bit read wrong");
  a_protect_combines: assert property (
    ##1 o_chk_protected == !($past(state_reg.persistent_protect_bit[chk_unit]) && $past(state_reg.volatile_protect_bit[chk_unit])))
    else $error("protection state mismatch");
  a_reset_unprotects: assert property (@(posedge i_clk)
    $past(i_sys_rst) |-> &state_reg.volatile_protect_bit && !o_busy)
    else $error("volatile bits not freed by reset");

  c_prog_done: cover property ($fell(o_busy) && !state_reg.erase_op);
  c_erase_done: cover property ($fell(o_busy) && state_reg.erase_op);
  c_lock_reject: cover property (o_cmd_fail);
  c_dyb_protect: cover property (o_chk_protected && &state_reg.persistent_protect_bit);
endmodule

// File: dv/host_prot_model.sv
// host controller model that issues protection commands to the block
`timescale 1ns/1ps
module host_prot_model (
  // clock
  input wire logic i_clk,
  // decoded command toward the block
  output sector_prot_pkg::prot_cmd_type o_cmd
);
  // ----------------------------------------------------------------
  // idle state
  // ----------------------------------------------------------------
  // quiet at time zero; between commands the address is inverted, never held
  initial begin
    o_cmd = '0;
  end

  // ----------------------------------------------------------------
  // one command, valid for a single cycle after an optional pause
  // ----------------------------------------------------------------
  // gap lets the bench play a slow host as well as one that sends a command every other cycle
  task automatic send(input sector_prot_pkg::prot_op_type op, input logic [6:0] unit,
                      input logic wdata, input int gap);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_cmd.valid <= 1'b1;
    o_cmd.op <= op;
    o_cmd.addr <= {unit, 18'h0};
    o_cmd.wdata <= wdata;
    @(posedge i_clk);
    o_cmd.valid <= 1'b0;
    o_cmd.addr <= ~{unit, 18'h0};
    o_cmd.wdata <= ~wdata;
  endtask
endmodule

// File: dv/test_sector_protection_bits.sv
// self-checking bench for the persistent and volatile protection bits
`timescale 1ns/1ps
module test_sector_protection_bits;
  // ----------------------------------------------------------------
  // signals and counters
  // ----------------------------------------------------------------
  localparam int PROG = 5; // shortened program time
  localparam int ERASE = 8; // shortened erase time
  logic clk;
  logic sys_rst;
  logic blk_256k;
  logic persistent_bits_lock;
  logic [24:0] chk_addr;
  sector_prot_pkg::prot_cmd_type cmd;
  logic busy, cmd_fail, rd_blk, rd_valid, rd_data, chk_prot;
  int failures = 0; // mismatches seen
  int tests_run = 0; // comparisons made
  int n;

  // ----------------------------------------------------------------
  // design, host model and clock
  // ----------------------------------------------------------------
  sector_protection_bits #(.PROG_CYCLES(PROG), .ERASE_CYCLES(ERASE)) dut (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_blk_size_256k(blk_256k),
    .i_persistent_bits_lock(persistent_bits_lock), .i_cmd(cmd), .i_chk_addr(chk_addr),
    .o_busy(busy), .o_cmd_fail(cmd_fail), .o_array_read_block(rd_blk),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_chk_protected(chk_prot));
  host_prot_model m_host (.i_clk(clk), .o_cmd(cmd));
  // 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // reset held 13 cycles; outputs checked after 12 while it is still applied
  task automatic do_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk);
    #1;
    check({busy, cmd_fail, rd_valid, rd_blk}, 0);
    check(chk_prot, 0);
    @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  // persistent bit read, answer one cycle after it is taken
  task automatic rd(input logic [6:0] unit, input logic exp);
    m_host.send(sector_prot_pkg::op_persistent_bit_read_cmd, unit, 1'b0, 0);
    #1;
    check(rd_valid, 1);
    check(rd_data, exp);
  endtask
  // protection query, result one cycle after the address is seen
  task automatic query(input logic [24:0] addr, input logic exp);
    @(posedge clk);
    chk_addr <= addr;
    repeat (2) @(posedge clk);
    #1;
    check(chk_prot, exp);
  endtask
  // bounded poll of busy; a hang ends the run as a failure
  // the leading step keeps the first look off the edge that launches busy
  task automatic wait_idle(input int maxc, output int cnt);
    #1;
    cnt = 0;
    while (busy === 1'b1 && cnt < maxc) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (busy !== 1'b0) begin
      failures++;
      $display("[ERR] %0t: busy did not fall", $time);
      tally_and_finish();
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // delivery state: all persistent bits erased, nothing protected
  task automatic s_fresh();
    rd(7'h00, 1);
    rd(7'h7F, 1);
    query(25'h1FFFFFF, 0);
  endtask
  // volatile bit toggled repeatedly, neighbour unit untouched
  task automatic s_dyb();
    for (int i = 0; i < 4; i++) begin
      m_host.send(sector_prot_pkg::op_dyb_write, 7'h05, i[0], i);
      query(25'h017FFFF, !i[0]);
      query(25'h013FFFF, 0);
    end
    // many rewrites in a row; the last one (0) must still take effect
    for (int i = 1; i <= 8; i++) begin
      m_host.send(sector_prot_pkg::op_dyb_write, 7'h05, i[0], 0);
    end
    query(25'h0140000, 1);
  endtask
  // program the top unit, with a read and a refused erase while busy
  task automatic s_prog();
    m_host.send(sector_prot_pkg::op_ppb_prog, 7'h7F, 1'b0, 0);
    #1;
    check(busy, 1);
    check(rd_blk, 1);
    rd(7'h7F, 1);
    m_host.send(sector_prot_pkg::op_ppb_erase, 7'h00, 1'b0, 0);
    #1;
    check(cmd_fail, 1);
    wait_idle(40, n);
    check(n >= 1 && n <= PROG + 3, 1);
    check(rd_blk, 0);
    rd(7'h7F, 0);
    rd(7'h7E, 1);
    query(25'h1FC0000, 1);
    query(25'h1FBFFFF, 0);
  endtask
  // locked bits or 64KB mapping refuse program and erase
  task automatic s_refuse();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      persistent_bits_lock <= i[1];
      blk_256k <= !i[1];
      m_host.send(i[0] ? sector_prot_pkg::op_ppb_erase : sector_prot_pkg::op_ppb_prog,
                  7'h03, 1'b0, 0);
      #1;
      check({cmd_fail, busy}, 2'b10);
    end
    rd(7'h7F, 0);
    rd(7'h03, 1);
    @(posedge clk);
    persistent_bits_lock <= 1'b1;
    blk_256k <= 1'b1;
  endtask
  // group erase with an arbitrary address returns every bit to 1
  task automatic s_erase();
    m_host.send(sector_prot_pkg::op_ppb_prog, 7'h00, 1'b0, 1);
    wait_idle(40, n);
    m_host.send(sector_prot_pkg::op_ppb_erase, 7'h55, 1'b0, 2);
    #1;
    check(rd_blk, 1);
    wait_idle(60, n);
    check(n >= PROG + ERASE, 1);
    rd(7'h00, 1);
    rd(7'h7F, 1);
  endtask
  // reset in mid-program: persistent bits kept, volatile bits cleared
  task automatic s_reset_mid();
    m_host.send(sector_prot_pkg::op_ppb_prog, 7'h09, 1'b0, 0);
    wait_idle(40, n);
    m_host.send(sector_prot_pkg::op_dyb_write, 7'h03, 1'b0, 0);
    query(25'h00C0000, 1);
    m_host.send(sector_prot_pkg::op_ppb_prog, 7'h14, 1'b0, 0);
    do_reset();
    rd(7'h09, 0);
    rd(7'h14, 1);
    query(25'h00C0000, 0);
    query(25'h0240000, 1);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    blk_256k = 1'b1;
    persistent_bits_lock = 1'b1;
    chk_addr = 25'h0;
    do_reset();
    s_fresh();
    s_dyb();
    s_prog();
    s_refuse();
    s_erase();
    s_reset_mid();
    tally_and_finish();
  end
endmodule
